//--- rtl/cpi_dev_end.sv
// device end: register access, vectored interrupt and daisy chain
`default_nettype none
`include "cpi_defs.svh"
module cpi_dev_end
  import cpi_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  cpi_bus_if.dev               bus,
  input  wire cpi_chan_src_t   irqSrc,
  input  wire cpi_chan_bytes_t bufStatus,
  input  wire cpi_chan_bytes_t spRxStatus,
  input  wire cpi_chan_bytes_t rxData,
  output logic                 inService,
  output cpi_chan_bytes_t      irqModeOut,
  output cpi_chan_bytes_t      rxParamOut,
  output cpi_chan_bytes_t      miscParamOut,
  output cpi_chan_bytes_t      txParamOut,
  output logic [7:0]           vectorOut,
  output logic [7:0]           txDataOut,
  output logic [1:0]           txWriteOut,
  output logic [1:0]           rxReadOut,
  output logic [2:0]           cmdCodeOut,
  output logic [1:0]           cmdStrobeOut
);

  cpi_dev_state_t s_r;
  cpi_dev_state_t s_nxt;

  logic       ioAct;
  logic       ackAct;
  logic       accStart;
  logic       ch;
  logic       anyPend;
  logic       retiHit;
  logic [5:0] livePend;
  logic [2:0] cmd;

  // ************************************************************
  // vector with status code
  // ************************************************************
  // fixed internal priority
  function automatic logic [7:0] modVec(input logic [7:0] vec,
                                        input logic       sav,
                                        input logic [5:0] pend);
    logic [2:0] code;
    logic [1:0] srcCode;
    logic [7:0] v;
    code = `CPI_NONE_CODE;
    v    = vec;
    for (int c = 1; c >= 0; c--) begin
      for (int src = 0; src < 3; src++) begin
        if (src == `CPI_SRC_RX) begin
          srcCode = `CPI_CODE_RX;
        end else if (src == `CPI_SRC_TX) begin
          srcCode = `CPI_CODE_TX;
        end else begin
          srcCode = `CPI_CODE_EXT;
        end
        if (pend[c*3+src]) begin
          code = {(c == 0), srcCode};
        end
      end
    end
    if (sav) begin
      v[`CPI_VEC_MSB:`CPI_VEC_LSB] = code;
    end
    return v;
  endfunction

  // ************************************************************
  // enabled interrupt sources
  // ************************************************************
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      livePend[c*3+`CPI_SRC_RX]  = irqSrc[c][`CPI_SRC_RX] &
        (|s_r.irqMode[c][`CPI_WR1_RX_MSB:`CPI_WR1_RX_LSB]);
      livePend[c*3+`CPI_SRC_TX]  = irqSrc[c][`CPI_SRC_TX] &
        s_r.irqMode[c][`CPI_WR1_TX_EN];
      livePend[c*3+`CPI_SRC_EXT] = irqSrc[c][`CPI_SRC_EXT] &
        s_r.irqMode[c][`CPI_WR1_EXT_EN];
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt           = s_r;
    s_nxt.txWrite   = 2'h0;
    s_nxt.rxRead    = 2'h0;
    s_nxt.cmdStrobe = 2'h0;
    retiHit         = 1'b0;
    ch       = bus.channelSelect;
    ioAct    = ~bus.chipEnableN & ~bus.ioRequestN & bus.fetchCycleN;
    ackAct   = ~bus.fetchCycleN & ~bus.ioRequestN;
    accStart = (ioAct | ackAct) & ~s_r.busSeen;
    cmd      = bus.dataBus[`CPI_CMD_MSB:`CPI_CMD_LSB];
    anyPend  = |s_r.pendHold;
    s_nxt.busSeen = ioAct | ackAct;

    if (bus.fetchCycleN) begin
      s_nxt.pendHold = livePend;
    end

    if (accStart & ackAct) begin
      s_nxt.ackInFetch = 1'b1;
      if (bus.chainEnableIn & anyPend & ~s_r.inService) begin
        s_nxt.dataOut   = modVec(s_r.vector,
                                 s_r.irqMode[`CPI_CH_B][`CPI_WR1_SAV],
                                 s_r.pendHold);
        s_nxt.driveOut  = 1'b1;
        s_nxt.inService = 1'b1;
      end
    end else if (accStart & ~bus.readStrobeN) begin
      s_nxt.driveOut = 1'b1;
      if (bus.controlDataSelect) begin
        case (s_r.ptr[ch])
          `CPI_IDX_CMD: s_nxt.dataOut = bufStatus[ch];
          `CPI_IDX_SRX: s_nxt.dataOut = spRxStatus[ch];
          `CPI_IDX_VRD: begin
            // vector read only in channel B
            if (ch == `CPI_CH_B) begin
              s_nxt.dataOut = modVec(s_r.vector,
                                     s_r.irqMode[`CPI_CH_B][`CPI_WR1_SAV],
                                     s_r.pendHold);
            end else begin
              s_nxt.dataOut = `CPI_RST_BYTE;
            end
          end
          default: s_nxt.dataOut = `CPI_RST_BYTE;
        endcase
        // pointer back to zero after read
        s_nxt.ptr[ch] = `CPI_RST_PTR;
      end else begin
        s_nxt.dataOut    = rxData[ch];
        s_nxt.rxRead[ch] = 1'b1;
      end
    end else if (accStart) begin
      if (!bus.controlDataSelect) begin
        s_nxt.txData      = bus.dataBus;
        s_nxt.txWrite[ch] = 1'b1;
      end else if (s_r.ptr[ch] == `CPI_IDX_CMD) begin
        s_nxt.cmdCode       = cmd;
        s_nxt.cmdStrobe[ch] = 1'b1;
        s_nxt.ptr[ch] = bus.dataBus[`CPI_PTR_MSB:`CPI_PTR_LSB];
        if (cmd == `CPI_CMD_CHRST) begin
          s_nxt.ptr[ch]       = `CPI_RST_PTR;
          s_nxt.irqMode[ch]   = `CPI_RST_BYTE;
          s_nxt.rxParam[ch]   = `CPI_RST_BYTE;
          s_nxt.miscParam[ch] = `CPI_RST_BYTE;
          s_nxt.txParam[ch]   = `CPI_RST_BYTE;
        end
        if (cmd == `CPI_CMD_RETURN_FROM_IRQ_OPCODE && ch == `CPI_CH_A) begin
          retiHit = 1'b1;
        end
      end else begin
        case (s_r.ptr[ch])
          `CPI_IDX_IRQ:  s_nxt.irqMode[ch]   = bus.dataBus;
          `CPI_IDX_RX:   s_nxt.rxParam[ch]   = bus.dataBus;
          `CPI_IDX_MISC: s_nxt.miscParam[ch] = bus.dataBus;
          `CPI_IDX_TX:   s_nxt.txParam[ch]   = bus.dataBus;
          `CPI_IDX_VEC: begin
            // vector write only in channel B
            if (ch == `CPI_CH_B) begin
              s_nxt.vector = bus.dataBus;
            end
          end
          default: s_nxt.vector = s_r.vector;
        endcase
        // pointer back to zero after word
        s_nxt.ptr[ch] = `CPI_RST_PTR;
      end
    end

    if (!(ioAct | ackAct)) begin
      s_nxt.driveOut = 1'b0;
    end

    // ************************************************************
    // opcode watch on fetch cycles
    // ************************************************************
    s_nxt.fetchSeen = ~bus.fetchCycleN;
    if (!bus.fetchCycleN) begin
      s_nxt.fetchByte = bus.dataBus;
    end
    if (s_r.fetchSeen & bus.fetchCycleN) begin
      s_nxt.ackInFetch = 1'b0;
      if (!s_r.ackInFetch) begin
        if (s_r.sawPrefix && s_r.fetchByte == `CPI_OP_RETURN_FROM_IRQ_OPCODE) begin
          retiHit = 1'b1;
        end
        s_nxt.sawPrefix = (s_r.fetchByte == `CPI_OP_PREFIX);
      end
    end
    // only the device whose chain input is high ends its service
    if (retiHit & bus.chainEnableIn) begin
      s_nxt.inService = 1'b0;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // pass through when idle
  // block chain when pending or served
  assign bus.chainEnableOut = bus.chainEnableIn & ~(|s_r.pendHold) &
                              ~s_r.inService;
  assign bus.irqOut    = 1'b0;
  assign bus.irqOe     = (|s_r.pendHold) & ~s_r.inService;
  assign bus.devData   = s_r.dataOut;
  assign bus.devDataOe = s_r.driveOut & (ioAct | ackAct);

  assign inService    = s_r.inService;
  assign irqModeOut   = s_r.irqMode;
  assign rxParamOut   = s_r.rxParam;
  assign miscParamOut = s_r.miscParam;
  assign txParamOut   = s_r.txParam;
  assign vectorOut    = s_r.vector;
  assign txDataOut    = s_r.txData;
  assign txWriteOut   = s_r.txWrite;
  assign rxReadOut    = s_r.rxRead;
  assign cmdCodeOut   = s_r.cmdCode;
  assign cmdStrobeOut = s_r.cmdStrobe;

endmodule
`default_nettype wire

//--- rtl/cpi_defs.svh
// constants shared by both ends of the cpu port and interrupt chain
`ifndef CPI_DEFS_SVH
`define CPI_DEFS_SVH

// register indices reached through the pointer
`define CPI_IDX_CMD     3'h0
`define CPI_IDX_IRQ     3'h1
`define CPI_IDX_VEC     3'h2
`define CPI_IDX_RX      3'h3
`define CPI_IDX_MISC    3'h4
`define CPI_IDX_TX      3'h5
`define CPI_IDX_SRX     3'h1
`define CPI_IDX_VRD     3'h2

// pointer_command_reg fields
`define CPI_PTR_MSB     2
`define CPI_PTR_LSB     0
`define CPI_CMD_MSB     5
`define CPI_CMD_LSB     3
`define CPI_CMD_CHRST   3'h3
`define CPI_CMD_RETURN_FROM_IRQ_OPCODE    3'h7

// irq_transfer_mode_reg fields
`define CPI_WR1_EXT_EN  0
`define CPI_WR1_TX_EN   1
`define CPI_WR1_SAV     2
`define CPI_WR1_RX_LSB  3
`define CPI_WR1_RX_MSB  4

// vector modification
`define CPI_VEC_LSB     1
`define CPI_VEC_MSB     3
`define CPI_NONE_CODE   3'h3
`define CPI_CODE_TX     2'h0
`define CPI_CODE_EXT    2'h1
`define CPI_CODE_RX     2'h2
`define CPI_SRC_EXT     0
`define CPI_SRC_TX      1
`define CPI_SRC_RX      2
`define CPI_CH_A        1'h0
`define CPI_CH_B        1'h1

// return-from-interrupt opcode bytes
`define CPI_OP_PREFIX   8'hED
`define CPI_OP_RETURN_FROM_IRQ_OPCODE     8'h4D

// reset values
`define CPI_RST_BYTE    8'h00
`define CPI_RST_PTR     3'h0
`define CPI_BUS_IDLE    8'hFF

// host cycle lengths: last phase index of each cycle, io request phase of acknowledge, counter steps
`define CPI_IO_LAST     2'h2
`define CPI_ACK_IO      2'h2
`define CPI_ACK_LAST    2'h3
`define CPI_FETCH_LAST  2'h1
`define CPI_CNT_ZERO    2'h0
`define CPI_CNT_ONE     2'h1

`endif

//--- rtl/cpi_pkg.sv
// types shared by both ends of the cpu port and interrupt chain
`default_nettype none
package cpi_pkg;

  typedef logic [1:0][7:0] cpi_chan_bytes_t;
  typedef logic [1:0][2:0] cpi_chan_src_t;

  typedef struct packed {
    cpi_chan_bytes_t irqMode;
    cpi_chan_bytes_t rxParam;
    cpi_chan_bytes_t miscParam;
    cpi_chan_bytes_t txParam;
    logic [7:0]      vector;
    cpi_chan_src_t   ptr;
    logic [5:0]      pendHold;
    logic            inService;
    logic            busSeen;
    logic            fetchSeen;
    logic            ackInFetch;
    logic            driveOut;
    logic [7:0]      dataOut;
    logic [7:0]      fetchByte;
    logic            sawPrefix;
    logic [7:0]      txData;
    logic [1:0]      txWrite;
    logic [1:0]      rxRead;
    logic [2:0]      cmdCode;
    logic [1:0]      cmdStrobe;
  } cpi_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_IO,
    HS_ACK,
    HS_FETCH,
    HS_GAP
  } cpi_host_st_t;

  typedef struct packed {
    cpi_host_st_t st;
    logic [1:0]   cnt;
    logic         write;
    logic         chan;
    logic         ctrl;
    logic [7:0]   data;
    logic         moreByte;
    logic         rspValid;
    logic         rspIsVector;
    logic [7:0]   rspData;
  } cpi_host_state_t;

endpackage
`default_nettype wire

//--- rtl/cpi_bus_if.sv
// cpu bus, interrupt request and daisy chain between host and device
`default_nettype none
`include "cpi_defs.svh"
interface cpi_bus_if;
  logic       chipEnableN;
  logic       channelSelect;
  logic       controlDataSelect;
  logic       ioRequestN;
  logic       readStrobeN;
  logic       fetchCycleN;
  logic [7:0] cpuData;
  logic       cpuDataOe;
  logic [7:0] devData;
  logic       devDataOe;
  logic [7:0] dataBus;
  logic       irqOut;
  logic       irqOe;
  logic       irqRequestN;
  logic       chainEnableIn;
  logic       chainEnableOut;

  // wire resolution: device wins, idle bus floats high
  assign dataBus     = devDataOe ? devData
                     : (cpuDataOe ? cpuData : `CPI_BUS_IDLE);
  assign irqRequestN = irqOe ? irqOut : 1'b1;

  modport dev (
    input  chipEnableN, channelSelect, controlDataSelect, ioRequestN,
    input  readStrobeN, fetchCycleN, dataBus, chainEnableIn,
    output devData, devDataOe, irqOut, irqOe, chainEnableOut
  );

  modport host (
    output chipEnableN, channelSelect, controlDataSelect, ioRequestN,
    output readStrobeN, fetchCycleN, cpuData, cpuDataOe, chainEnableIn,
    input  dataBus, irqRequestN, chainEnableOut
  );
endinterface
`default_nettype wire

//--- rtl/cpi_host_end.sv
// host end: cpu bus cycles, interrupt acknowledge and return opcode
`default_nettype none
`include "cpi_defs.svh"
module cpi_host_end
  import cpi_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  cpi_bus_if.host         bus,
  input  wire logic       reqValid,
  input  wire logic       reqWrite,
  input  wire logic       reqChannel,
  input  wire logic       reqControl,
  input  wire logic [7:0] reqData,
  output logic            reqReady,
  input  wire logic       ackReq,
  output logic            ackReady,
  input  wire logic       retiReq,
  output logic            retiReady,
  output logic            rspValid,
  output logic            rspIsVector,
  output logic [7:0]      rspData
);

  cpi_host_state_t s_r;
  cpi_host_state_t s_nxt;
  logic            idle;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rspValid = 1'b0;
    s_nxt.cnt      = s_r.cnt + `CPI_CNT_ONE;
    idle           = (s_r.st == HS_IDLE);
    case (s_r.st)
      HS_IDLE: begin
        s_nxt.cnt = `CPI_CNT_ZERO;
        if (ackReq & ~bus.irqRequestN) begin
          s_nxt.st = HS_ACK;
        end else if (retiReq) begin
          s_nxt.st       = HS_FETCH;
          s_nxt.data     = `CPI_OP_PREFIX;
          s_nxt.moreByte = 1'b1;
        end else if (reqValid) begin
          s_nxt.st    = HS_IO;
          s_nxt.write = reqWrite;
          s_nxt.chan  = reqChannel;
          s_nxt.ctrl  = reqControl;
          s_nxt.data  = reqData;
        end
      end
      HS_IO: begin
        if (s_r.cnt == `CPI_IO_LAST) begin
          s_nxt.st          = HS_GAP;
          s_nxt.rspValid    = ~s_r.write;
          s_nxt.rspIsVector = 1'b0;
          s_nxt.rspData     = bus.dataBus;
        end
      end
      HS_ACK: begin
        if (s_r.cnt == `CPI_ACK_LAST) begin
          s_nxt.st          = HS_GAP;
          s_nxt.rspValid    = 1'b1;
          s_nxt.rspIsVector = 1'b1;
          s_nxt.rspData     = bus.dataBus;
        end
      end
      HS_FETCH: begin
        if (s_r.cnt == `CPI_FETCH_LAST) begin
          s_nxt.st = HS_GAP;
        end
      end
      HS_GAP: begin
        s_nxt.cnt = `CPI_CNT_ZERO;
        s_nxt.st  = HS_IDLE;
        if (s_r.moreByte) begin
          s_nxt.st       = HS_FETCH;
          s_nxt.data     = `CPI_OP_RETURN_FROM_IRQ_OPCODE;
          s_nxt.moreByte = 1'b0;
        end
      end
      default: s_nxt.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // bus drive
  // ************************************************************
  assign bus.chipEnableN       = ~(s_r.st == HS_IO);
  assign bus.channelSelect     = s_r.chan;
  assign bus.controlDataSelect = s_r.ctrl;
  assign bus.ioRequestN  = ~((s_r.st == HS_IO) |
                            ((s_r.st == HS_ACK) &
                             (s_r.cnt >= `CPI_ACK_IO)));
  assign bus.fetchCycleN = ~((s_r.st == HS_ACK) | (s_r.st == HS_FETCH));
  assign bus.readStrobeN = ~((s_r.st == HS_IO) & ~s_r.write);
  assign bus.cpuData     = s_r.data;
  assign bus.cpuDataOe   = ((s_r.st == HS_IO) & s_r.write) |
                           (s_r.st == HS_FETCH);
  assign bus.chainEnableIn = 1'b1;

  assign reqReady    = idle & ~(ackReq & ~bus.irqRequestN) & ~retiReq;
  assign ackReady    = idle & ~bus.irqRequestN;
  assign retiReady   = idle & ~(ackReq & ~bus.irqRequestN);
  assign rspValid    = s_r.rspValid;
  assign rspIsVector = s_r.rspIsVector;
  assign rspData     = s_r.rspData;

endmodule
`default_nettype wire

//--- test/cpi_bus_chk.sv
// concurrent checks on the host-device bus and the interrupt chain
`default_nettype none
`include "cpi_defs.svh"
module cpi_bus_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       chipEnableN,
  input wire logic       channelSelect,
  input wire logic       controlDataSelect,
  input wire logic       ioRequestN,
  input wire logic       readStrobeN,
  input wire logic       fetchCycleN,
  input wire logic [7:0] dataBus,
  input wire logic       devDataOe,
  input wire logic       irqRequestN,
  input wire logic       chainEnableIn,
  input wire logic       chainEnableOut
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // opcode tracking
  // ****************************************
  logic       fetchD;
  logic [7:0] curOp;
  logic [7:0] prevOp;
  logic       ioRead;
  logic       ctlWrA;
  assign ioRead = fetchCycleN && !chipEnableN && !readStrobeN;
  assign ctlWrA = fetchCycleN && !chipEnableN && readStrobeN
                  && !channelSelect && controlDataSelect;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchD <= 1'b1;
      curOp  <= 8'hFF;
      prevOp <= 8'hFF;
    end else begin
      fetchD <= fetchCycleN;
      if (!fetchCycleN && ioRequestN) curOp <= dataBus;
      if (fetchCycleN && !fetchD) prevOp <= curOp;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_read_drive: assert property (
    $fell(ioRequestN) && ioRead |=> devDataOe)
    else $error("read not driven");
  a_write_quiet: assert property (
    !ioRequestN && fetchCycleN && readStrobeN |-> !devDataOe)
    else $error("device drove during write");
  a_idle_quiet: assert property (ioRequestN |-> !devDataOe)
    else $error("device drove idle bus");
  a_chain_gate: assert property (chainEnableOut |-> chainEnableIn)
    else $error("chain out high without chain in");
  a_chain_block: assert property (!irqRequestN |-> !chainEnableOut)
    else $error("chain open while pending");
  a_fetch_freeze: assert property (
    !fetchCycleN && $past(!fetchCycleN) |-> $stable(chainEnableOut))
    else $error("chain moved during fetch");
  a_ack_vector: assert property ($fell(ioRequestN) && !fetchCycleN
    && chainEnableIn && !irqRequestN |=> devDataOe)
    else $error("no vector on acknowledge");
  a_ack_service: assert property ($fell(ioRequestN) && !fetchCycleN
    && chainEnableIn && !irqRequestN |-> ##[1:2] irqRequestN)
    else $error("request kept after acknowledge");
  a_return_from_irq_opcode_clear: assert property (fetchCycleN && !fetchD
    && prevOp == `CPI_OP_PREFIX && curOp == `CPI_OP_RETURN_FROM_IRQ_OPCODE && chainEnableIn
    |-> ##[1:2] (chainEnableOut || !irqRequestN))
    else $error("service not ended by opcode");
  a_cmd_return_from_irq_opcode: assert property ($fell(ioRequestN) && ctlWrA
    && dataBus[`CPI_CMD_MSB:`CPI_CMD_LSB] == `CPI_CMD_RETURN_FROM_IRQ_OPCODE && chainEnableIn
    |-> ##[1:3] (chainEnableOut || !irqRequestN))
    else $error("service not ended by command");
  cov_ack: cover property ($fell(ioRequestN) && !fetchCycleN);
  cov_read: cover property ($fell(ioRequestN) && ioRead);
  cov_return_from_irq_opcode: cover property (fetchCycleN && !fetchD
    && curOp == `CPI_OP_RETURN_FROM_IRQ_OPCODE);
endmodule
`default_nettype wire

//--- test/tb_top.sv
// bench joining host end and device end across the cpu bus
`default_nettype none
`include "cpi_defs.svh"
module tb_top
  import cpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals and instances
  // ****************************************
  logic            sys_clk = 1'b0;
  logic            rst_b;
  logic            reqValid, reqWrite, reqChannel, reqControl;
  logic            ackReq, retiReq, reqReady, ackReady, retiReady;
  logic            rspValid, rspIsVector, inService;
  logic [7:0]      reqData, rspData, rdByte, vectorOut, txDataOut;
  logic [1:0]      txWrite, rxRead, cmdStrobe;
  logic [2:0]      cmdCode;
  cpi_chan_src_t   irqSrc;
  cpi_chan_bytes_t bufStatus, spRxStatus, rxData;
  cpi_chan_bytes_t irqMode, rxParam, miscParam, txParam;
  int              n_errors = 0;
  int              checks = 0;
  logic [5:0]      pulseLast = 6'h00;
  int              nPulse = 0;

  always #5 sys_clk = ~sys_clk;

  // latest one-cycle strobe pattern and count of strobe cycles
  always @(posedge sys_clk) begin
    if (|{txWrite, rxRead, cmdStrobe}) begin
      pulseLast <= {txWrite, rxRead, cmdStrobe};
      nPulse    <= nPulse + 1;
    end
  end

  cpi_bus_if bus ();
  cpi_host_end u_cpi_host_end (
    .sys_clk, .rst_b, .bus(bus), .reqValid, .reqWrite, .reqChannel,
    .reqControl, .reqData, .reqReady, .ackReq, .ackReady, .retiReq,
    .retiReady, .rspValid, .rspIsVector, .rspData
  );
  cpi_dev_end u_cpi_dev_end (
    .sys_clk, .rst_b, .bus(bus), .irqSrc, .bufStatus, .spRxStatus,
    .rxData, .inService, .irqModeOut(irqMode), .rxParamOut(rxParam),
    .miscParamOut(miscParam), .txParamOut(txParam), .vectorOut,
    .txDataOut, .txWriteOut(txWrite), .rxReadOut(rxRead),
    .cmdCodeOut(cmdCode), .cmdStrobeOut(cmdStrobe)
  );
  cpi_bus_chk u_cpi_bus_chk (
    .sys_clk, .rst_b, .chipEnableN(bus.chipEnableN),
    .channelSelect(bus.channelSelect),
    .controlDataSelect(bus.controlDataSelect),
    .ioRequestN(bus.ioRequestN), .readStrobeN(bus.readStrobeN),
    .fetchCycleN(bus.fetchCycleN), .dataBus(bus.dataBus),
    .devDataOe(bus.devDataOe), .irqRequestN(bus.irqRequestN),
    .chainEnableIn(bus.chainEnableIn),
    .chainEnableOut(bus.chainEnableOut)
  );
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // kind 0 plain access, 1 acknowledge, 2 return opcode
  task automatic req(input int kind, input logic wr, ch, ctl,
                     input logic [7:0] d);
    int i;
    bit late;
    i = 0;
    {reqWrite, reqChannel, reqControl, reqData} = {wr, ch, ctl, d};
    rdByte = 8'hXX;
    reqValid = (kind == 0);
    ackReq = (kind == 1);
    retiReq = (kind == 2);
    while (i < 20 && ((kind == 0) ? reqReady : (kind == 1) ? ackReady
           : retiReady) !== 1'b1) begin
      cyc(1);
      i++;
    end
    late = (i >= 20);
    cyc(1);
    {reqValid, ackReq, retiReq} = 3'h0;
    for (i = 0; i < 20 && reqReady !== 1'b1; i++) begin
      cyc(1);
      if (rspValid === 1'b1) rdByte = rspData;
    end
    if (late || i >= 20) begin
      n_errors++;
      $display("[FAIL] %0t ns: bus request timed out", $time);
    end
  endtask

  task automatic wr(input logic ch, ctl, input logic [7:0] d);
    req(0, 1'b1, ch, ctl, d);
  endtask

  task automatic rd(input logic ch, ctl);
    req(0, 1'b0, ch, ctl, 8'h00);
  endtask

  task automatic wReg(input logic ch, input logic [2:0] ix,
                      input logic [7:0] d);
    wr(ch, 1'b1, {5'h00, ix});
    wr(ch, 1'b1, d);
  endtask

  function automatic logic [7:0] pv(input int c, input int k);
    return 8'h40 + 8'(c * 8 + k);
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testReset();
    chk(irqMode | rxParam, 16'h0000); // regs clear
    chk(miscParam | txParam, 16'h0000); // regs clear
    chk({inService, bus.chainEnableOut}, 16'h0001); // chain open
    rd(1'b0, 1'b1);
    chk(rdByte, bufStatus[0]); // status read
  endtask

  task automatic testRegs();
    logic [2:0] ix [4];
    int         n;
    ix = '{3'h4, 3'h1, 3'h3, 3'h5};
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) wReg(c[0], ix[k], pv(c, k)); // pairs
      chk({irqMode[c], rxParam[c]}, {pv(c, 1), pv(c, 2)}); // roles
      chk({miscParam[c], txParam[c]}, {pv(c, 0), pv(c, 3)}); // roles
      rd(c[0], 1'b1);
      chk(rdByte, bufStatus[c]); // pointer back
      n = nPulse;
      rd(c[0], 1'b0);
      chk(rdByte, rxData[c]); // data path
      chk(16'(nPulse - n), 16'h0001); // one read strobe
      chk(pulseLast, {2'h0, c[0], !c[0], 2'h0}); // read strobe
    end
    wr(1'b1, 1'b0, 8'h5A);
    chk(txDataOut, 8'h5A); // data write
    chk(pulseLast, 6'h20); // channel B write strobe
  endtask

  task automatic testChanReset();
    wr(1'b0, 1'b1, 8'h19);
    chk(cmdCode, 16'h0003); // single byte
    chk(pulseLast, 6'h01); // command strobe A
    chk(irqMode[0] | rxParam[0] | miscParam[0] | txParam[0], 0);
    chk(txParam[1], pv(1, 3)); // other kept
    rd(1'b0, 1'b1);
    chk(rdByte, bufStatus[0]); // pointer dropped
    wr(1'b0, 1'b1, 8'h01);
    rd(1'b0, 1'b1);
    chk(rdByte, spRxStatus[0]); // pointed read
    wr(1'b0, 1'b1, 8'h02);
    rd(1'b0, 1'b1);
    chk(rdByte, 16'h0000); // no vector on A
  endtask

  task automatic testIrq();
    cpi_chan_src_t src [8];
    logic [2:0]    code [8];
    src = '{6'h04, 6'h02, 6'h01, 6'h20, 6'h10, 6'h08, 6'h22, 6'h03};
    code = '{3'h6, 3'h4, 3'h5, 3'h2, 3'h0, 3'h1, 3'h4, 3'h4};
    wReg(1'b1, 3'h2, 8'hA0);
    wReg(1'b0, 3'h1, 8'h1B);
    wReg(1'b1, 3'h1, 8'h1F);
    wr(1'b1, 1'b1, 8'h02);
    rd(1'b1, 1'b1);
    chk({vectorOut, rdByte}, 16'hA0A6); // vector read
    wReg(1'b0, 3'h2, 8'h55); // vector write on A
    chk(vectorOut, 8'hA0); // A write dropped
    for (int k = 0; k < 8; k++) begin
      irqSrc = src[k];
      cyc(3);
      chk({bus.irqRequestN, bus.chainEnableOut}, 16'h0000);
      chk({ackReady, retiReady}, 16'h0003); // ack offered
      req(1, 1'b0, 1'b0, 1'b0, 8'h00);
      chk({rspIsVector, rdByte}, {8'h01, 4'hA, code[k], 1'b0});
      chk(inService, 16'h0001); // in service
      irqSrc = 6'h00;
      cyc(3);
      chk(bus.chainEnableOut, 16'h0000); // still blocked
      chk(ackReady, 16'h0000); // no request, no ack
      if (k[0]) wr(1'b0, 1'b1, 8'h38); // command return
      else req(2, 1'b0, 1'b0, 1'b0, 8'h00); // opcode return
      cyc(2);
      chk({inService, bus.chainEnableOut}, 16'h0001);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    {reqValid, reqWrite, reqChannel, reqControl, ackReq, retiReq} = 6'h00;
    reqData = 8'h00;
    rdByte = 8'h00;
    irqSrc = 6'h00;
    bufStatus = 16'hB1A0;
    spRxStatus = 16'hC3C2;
    rxData = 16'hD5D4;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    testReset();
    testRegs();
    testChanReset();
    testIrq();
    test_done();
  end

  // about thirty times the expected run
  initial begin
    #100us;
    n_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
